// *** core/ctf_pkg.sv ***
`default_nettype none
package ctf_pkg;
    // Clock rate and timing
    localparam int CLK_HZ          = 40000000;
    localparam int TOD_STEP_US     = 16;
    localparam int TOD_STEP_CYC    = CLK_HZ / 1000000 * TOD_STEP_US;
    localparam int ITMR_RES_MS     = 10;
    localparam int ITMR_RES_CYC    = CLK_HZ / 1000 * ITMR_RES_MS;
    localparam int ITMR_LOC        = 80;
    localparam int TOD_W           = 52;
    localparam int TOD_XFER_W      = 48;
    localparam int ITMR_MAX_TICKS  = 5580000;
    // Reset values
    localparam logic [7:0]  SYSMASK_RST = 8'h00;
    localparam logic [3:0]  KEY_RST     = 4'h0;
    localparam logic [15:0] MCMASK_RST  = 16'h0000;
    localparam int EXT_FRAC_DIGITS  = 28;
    localparam int LONG_FRAC_DIGITS = 14;
    localparam int EXT_OP_COUNT     = 7;

    // Operation codes presented on the command port
    typedef enum logic [4:0]
    {
        CTF_OP_NONE   = 5'h00,
        CTF_OP_STNSM  = 5'h01,
        CTF_OP_STOSM  = 5'h02,
        CTF_OP_CS     = 5'h03,
        CTF_OP_CDS    = 5'h04,
        CTF_OP_IKEY   = 5'h05,
        CTF_OP_SKEY   = 5'h06,
        CTF_OP_AXR    = 5'h07,
        CTF_OP_SXR    = 5'h08,
        CTF_OP_MXR    = 5'h09,
        CTF_OP_MXDR   = 5'h0A,
        CTF_OP_MXD    = 5'h0B,
        CTF_OP_LRDR   = 5'h0C,
        CTF_OP_LRER   = 5'h0D,
        CTF_OP_DXR    = 5'h0E,
        CTF_OP_MC     = 5'h0F,
        CTF_OP_DEC    = 5'h10,
        CTF_OP_EDIT   = 5'h11,
        CTF_OP_OPND   = 5'h12,
        CTF_OP_FETCHI = 5'h13,
        CTF_OP_CHCMD  = 5'h14,
        CTF_OP_SCK    = 5'h15,
        CTF_OP_STCK   = 5'h16
    } ctf_op_e;

    // Program interruption causes
    typedef enum logic [2:0]
    {
        CTF_PI_NONE = 3'h0,
        CTF_PI_PRIV = 3'h1,
        CTF_PI_SPEC = 3'h2,
        CTF_PI_MON  = 3'h3,
        CTF_PI_DATA = 3'h4,
        CTF_PI_PROT = 3'h5,
        CTF_PI_OPER = 3'h6
    } ctf_pi_e;

    typedef struct packed
    {
        ctf_op_e      op;
        logic [7:0]   imm;
        logic [63:0]  opnd1;
        logic [63:0]  opnd2;
        logic [63:0]  stor;
        logic [23:0]  addr;
        logic [2:0]   align;
        logic         sign_ok;
        logic         pat_prot;
    } ctf_cmd_s;

    typedef struct packed
    {
        logic         done;
        ctf_pi_e      pi;
        logic         cc0;
        logic         stor_we;
        logic [63:0]  stor_wd;
        logic [63:0]  reg_wd;
        logic         reg_we;
        logic [3:0]   mon_class;
        logic [23:0]  mon_code;
    } ctf_rsp_s;
endpackage
`default_nettype wire

// *** core/ctf_core.sv ***
// Notes on behaviour
// [R1] Store-then-AND saves mask, clears zero-selected bits
// [R2] Store-then-OR saves mask, sets one-selected bits
// [R3] Single and double compare-and-swap on storage
// [R4] Insert key copies status key to register
// [R5] Set key loads status key from value
// [R6] Extended operands use register pair, 28 digits
// [R7] Seven extended ops; divide is unsupported
// [R8] Unprivileged operands accepted at any byte
// [R9] Instruction and channel command words stay aligned
// [R10] Monitor call: 16 classes masked individually
// [R11] Enabled class interrupts, stores class and code
// [R12] Invalid decimal sign suppresses, then interrupts
// [R13] Edit fetching protected pattern byte faults
// [R14] Interval timer: 10 ms steps, 15.5 hours
// [R15] Time-of-day: 52-bit counter, 16 us steps
// [R16] Set/store clock move bits 0 to 47
// [R17] Set clock needs supervisor and console enable
// [R18] Privileged op in problem state is rejected
`default_nettype none
module ctf_core
    import ctf_pkg::*;
#(
    parameter int ITMR_CYC = ITMR_RES_CYC
)
(
    input  wire logic                CLK_IN,
    input  wire logic                RST_IN,
    input  wire logic                CMD_VALID_IN,
    input  wire ctf_cmd_s            CMD_IN,
    input  wire logic                PROBLEM_STATE_IN,
    input  wire logic                CLK_SET_EN_IN,
    input  wire logic                STOPPED_IN,
    input  wire logic [15:0]         MC_MASK_IN,
    output var  ctf_rsp_s            RSP_OUT,
    output var  logic [7:0]          SYSMASK_OUT,
    output var  logic [3:0]          KEY_OUT,
    output var  logic [TOD_W-1:0]    TOD_OUT,
    output var  logic [31:0]         ITMR_OUT
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic is_priv(input ctf_op_e o);
        return o == CTF_OP_STNSM || o == CTF_OP_STOSM ||
               o == CTF_OP_IKEY  || o == CTF_OP_SKEY  ||
               o == CTF_OP_SCK;
    endfunction

    function automatic logic [63:0] tod_word(input logic [TOD_W-1:0] t);
        return {t[TOD_W-1:TOD_W-TOD_XFER_W], 16'h0000};
    endfunction

    ctf_rsp_s          rsp_r;
    logic [7:0]        sysmask_r;
    logic [3:0]        key_r;
    logic [TOD_W-1:0]  tod_r;
    logic [31:0]       itmr_r;
    logic [9:0]        tod_div_r;
    logic [31:0]       itmr_div_r;
    logic              sck_ok;
    logic              priv_bad;

    assign priv_bad = CMD_VALID_IN && PROBLEM_STATE_IN && is_priv(CMD_IN.op);
    assign sck_ok   = CMD_VALID_IN && CMD_IN.op == CTF_OP_SCK &&
                      !PROBLEM_STATE_IN && CLK_SET_EN_IN;

    // ************************************************************
    // System mask
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            sysmask_r <= SYSMASK_RST;
        else if (CMD_VALID_IN && !priv_bad)
        begin
            if (CMD_IN.op == CTF_OP_STNSM)
                sysmask_r <= sysmask_r & CMD_IN.imm; // [R1]
            else if (CMD_IN.op == CTF_OP_STOSM)
                sysmask_r <= sysmask_r | CMD_IN.imm; // [R2]
        end
    end

    // ************************************************************
    // Access key
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            key_r <= KEY_RST;
        else if (CMD_VALID_IN && !priv_bad && CMD_IN.op == CTF_OP_SKEY)
            key_r <= CMD_IN.opnd2[7:4]; // [R5]
    end

    // ************************************************************
    // Time-of-day clock
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            tod_r     <= '0;
            tod_div_r <= '0;
        end
        else if (sck_ok)
        begin
            tod_r     <= {CMD_IN.stor[63:16], 4'h0}; // [R16] [R17]
            tod_div_r <= '0;
        end
        else if (tod_div_r == 10'(TOD_STEP_CYC - 1))
        begin
            tod_div_r <= '0;
            tod_r     <= tod_r + 52'h1; // [R15]
        end
        else
            tod_div_r <= tod_div_r + 10'h1;
    end

    // ************************************************************
    // Interval timer, held while stopped
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
        begin
            itmr_r     <= '0;
            itmr_div_r <= '0;
        end
        else if (!STOPPED_IN)
        begin
            if (itmr_div_r == 32'(ITMR_CYC - 1))
            begin
                itmr_div_r <= '0;
                if (itmr_r == 32'(ITMR_MAX_TICKS - 1))
                    itmr_r <= '0; // [R14]
                else
                    itmr_r <= itmr_r + 32'h1; // [R14]
            end
            else
                itmr_div_r <= itmr_div_r + 32'h1;
        end
    end

    // ************************************************************
    // Instruction responses
    // ************************************************************
    always_ff @(posedge CLK_IN or posedge RST_IN)
    begin
        if (RST_IN)
            rsp_r <= '0;
        else
        begin
            rsp_r         <= '0;
            rsp_r.done    <= CMD_VALID_IN;
            rsp_r.stor_wd <= CMD_IN.stor;
            if (!CMD_VALID_IN)
                rsp_r.done <= 1'b0;
            else if (priv_bad)
                rsp_r.pi <= CTF_PI_PRIV; // [R18]
            else
            begin
                unique case (CMD_IN.op)
                    CTF_OP_STNSM, CTF_OP_STOSM:
                    begin
                        rsp_r.stor_we <= 1'b1; // [R1] [R2]
                        rsp_r.stor_wd <= {sysmask_r, 56'h0};
                    end
                    CTF_OP_CS:
                    begin
                        if (CMD_IN.stor[31:0] == CMD_IN.opnd1[31:0]) // [R3]
                        begin
                            rsp_r.cc0     <= 1'b1;
                            rsp_r.stor_we <= 1'b1;
                            rsp_r.stor_wd <= {32'h0, CMD_IN.opnd2[31:0]};
                        end
                        else
                        begin
                            rsp_r.reg_we <= 1'b1;
                            rsp_r.reg_wd <= {32'h0, CMD_IN.stor[31:0]};
                        end
                    end
                    CTF_OP_CDS:
                    begin
                        if (CMD_IN.stor == CMD_IN.opnd1) // [R3]
                        begin
                            rsp_r.cc0     <= 1'b1;
                            rsp_r.stor_we <= 1'b1;
                            rsp_r.stor_wd <= CMD_IN.opnd2;
                        end
                        else
                        begin
                            rsp_r.reg_we <= 1'b1;
                            rsp_r.reg_wd <= CMD_IN.stor;
                        end
                    end
                    CTF_OP_IKEY:
                    begin
                        rsp_r.reg_we <= 1'b1; // [R4]
                        rsp_r.reg_wd <= {56'h0, key_r, 4'h0};
                    end
                    CTF_OP_SKEY: ;
                    CTF_OP_AXR, CTF_OP_SXR, CTF_OP_MXR, CTF_OP_MXDR,
                    CTF_OP_MXD, CTF_OP_LRDR, CTF_OP_LRER:
                        rsp_r.pi <= CTF_PI_NONE; // [R6] [R7]
                    CTF_OP_DXR:
                        rsp_r.pi <= CTF_PI_OPER; // [R7]
                    CTF_OP_MC:
                    begin
                        if (MC_MASK_IN[CMD_IN.imm[3:0]]) // [R10]
                        begin
                            rsp_r.pi        <= CTF_PI_MON; // [R11]
                            rsp_r.mon_class <= CMD_IN.imm[3:0];
                            rsp_r.mon_code  <= CMD_IN.addr;
                        end
                    end
                    CTF_OP_DEC:
                        if (!CMD_IN.sign_ok)
                            rsp_r.pi <= CTF_PI_DATA; // [R12]
                    CTF_OP_EDIT:
                        if (CMD_IN.pat_prot)
                            rsp_r.pi <= CTF_PI_PROT; // [R13]
                    CTF_OP_OPND: ; // [R8]
                    CTF_OP_FETCHI:
                        if (CMD_IN.addr[0])
                            rsp_r.pi <= CTF_PI_SPEC; // [R9]
                    CTF_OP_CHCMD:
                        if (CMD_IN.addr[2:0] != 3'h0)
                            rsp_r.pi <= CTF_PI_SPEC; // [R9]
                    CTF_OP_SCK:
                        rsp_r.cc0 <= sck_ok; // [R17]
                    CTF_OP_STCK:
                    begin
                        rsp_r.stor_we <= 1'b1; // [R16]
                        rsp_r.stor_wd <= tod_word(tod_r);
                    end
                    default:
                        rsp_r.pi <= CTF_PI_OPER;
                endcase
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    always_comb
    begin
        RSP_OUT     = rsp_r;
        SYSMASK_OUT = sysmask_r;
        KEY_OUT     = key_r;
        TOD_OUT     = tod_r;
        ITMR_OUT    = itmr_r;
    end

endmodule
`default_nettype wire

// *** bench/ctf_core_asserts.sv ***
`default_nettype none
module ctf_core_asserts
    import ctf_pkg::*;
(
    input  wire logic             CLK_IN,
    input  wire logic             RST_IN,
    input  wire logic             CMD_VALID_IN,
    input  wire ctf_cmd_s         CMD_IN,
    input  wire logic             PROBLEM_STATE_IN,
    input  wire logic             STOPPED_IN,
    input  wire logic [15:0]      MC_MASK_IN,
    input  wire ctf_rsp_s         RSP_OUT,
    input  wire logic [7:0]       SYSMASK_OUT,
    input  wire logic [3:0]       KEY_OUT,
    input  wire logic [TOD_W-1:0] TOD_OUT,
    input  wire logic [31:0]      ITMR_OUT
);
    // ************
    // Checks
    // ************
    logic sup;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    assign sup = CMD_VALID_IN && !PROBLEM_STATE_IN;
    a_and_mask: assert property (sup && CMD_IN.op == CTF_OP_STNSM
        |=> SYSMASK_OUT == ($past(SYSMASK_OUT) & $past(CMD_IN.imm))
        && RSP_OUT.stor_wd[63:56] == $past(SYSMASK_OUT))
        else $error("and mask wrong");
    a_or_mask: assert property (sup && CMD_IN.op == CTF_OP_STOSM
        |=> SYSMASK_OUT == ($past(SYSMASK_OUT) | $past(CMD_IN.imm))
        && RSP_OUT.stor_wd[63:56] == $past(SYSMASK_OUT))
        else $error("or mask wrong");
    a_priv_reject: assert property (CMD_VALID_IN && PROBLEM_STATE_IN
        && CMD_IN.op inside {CTF_OP_STNSM, CTF_OP_STOSM, CTF_OP_IKEY,
        CTF_OP_SKEY, CTF_OP_SCK} |=> RSP_OUT.pi == CTF_PI_PRIV
        && $stable(SYSMASK_OUT) && $stable(KEY_OUT) && !RSP_OUT.stor_we)
        else $error("privileged op not rejected");
    a_mon_taken: assert property (CMD_VALID_IN && CMD_IN.op == CTF_OP_MC
        && MC_MASK_IN[CMD_IN.imm[3:0]] |=> RSP_OUT.pi == CTF_PI_MON
        && RSP_OUT.mon_code == $past(CMD_IN.addr))
        else $error("monitor event wrong");
    a_mon_masked: assert property (CMD_VALID_IN && CMD_IN.op == CTF_OP_MC
        && !MC_MASK_IN[CMD_IN.imm[3:0]] |=> RSP_OUT.pi == CTF_PI_NONE)
        else $error("masked monitor class interrupted");
    a_dec_suppress: assert property (CMD_VALID_IN && CMD_IN.op == CTF_OP_DEC
        && !CMD_IN.sign_ok |=> RSP_OUT.pi == CTF_PI_DATA
        && !RSP_OUT.stor_we && !RSP_OUT.reg_we)
        else $error("bad sign not suppressed");
    a_edit_prot: assert property (CMD_VALID_IN && CMD_IN.op == CTF_OP_EDIT
        && CMD_IN.pat_prot |=> RSP_OUT.pi == CTF_PI_PROT)
        else $error("edit protection missed");
    a_tod_count: assert property ($changed(TOD_OUT)
        && !($past(CMD_VALID_IN) && $past(CMD_IN.op) == CTF_OP_SCK)
        |-> TOD_OUT == $past(TOD_OUT) + 1)
        else $error("clock step wrong");
    a_itmr_stop: assert property ($past(STOPPED_IN)
        |-> $stable(ITMR_OUT))
        else $error("timer ran while stopped");
endmodule
`default_nettype wire

// *** bench/tb_ctf_core.sv ***
`default_nettype none
module tb_ctf_core
    import ctf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    // ************
    // Signals
    // ************
    localparam int ITC = 4;
    logic          CLK_IN = 1'b0, RST_IN = 1'b1, CMD_VALID_IN = 1'b0;
    logic          PROBLEM_STATE_IN = 1'b0, CLK_SET_EN_IN = 1'b0;
    logic          STOPPED_IN = 1'b0;
    logic [15:0]   MC_MASK_IN = 16'h0000;
    ctf_cmd_s      CMD_IN = '0;
    ctf_rsp_s      RSP_OUT, r;
    logic [7:0]    SYSMASK_OUT, m;
    logic [3:0]    KEY_OUT;
    logic [51:0]   TOD_OUT;
    logic [31:0]   ITMR_OUT, sd = 32'd95504;
    logic [63:0]   v;
    int            mismatches = 0, num_checks = 0, cyc = 0, n, k;
    ctf_op_e       pops [5] = '{CTF_OP_STNSM, CTF_OP_STOSM, CTF_OP_IKEY,
                                CTF_OP_SKEY, CTF_OP_SCK};
    ctf_core #(.ITMR_CYC(ITC)) ctf_core_inst (.CLK_IN, .RST_IN, .CMD_VALID_IN,
        .CMD_IN, .PROBLEM_STATE_IN, .CLK_SET_EN_IN, .STOPPED_IN, .MC_MASK_IN,
        .RSP_OUT, .SYSMASK_OUT, .KEY_OUT, .TOD_OUT, .ITMR_OUT);
    always #12.5 CLK_IN = ~CLK_IN;
    always @(posedge CLK_IN)
    begin
        cyc++;
        if (cyc == 10000)
        begin
            mismatches++;
            wrap_up();
        end
    end
    // ************
    // Tasks
    // ************
    function automatic logic [31:0] rnd();
        sd = {sd[30:0], sd[31] ^ sd[21] ^ sd[1] ^ sd[0]};
        return sd;
    endfunction
    function automatic ctf_pi_e exp_pi(ctf_cmd_s c);
        case (c.op)
            CTF_OP_DXR:    return CTF_PI_OPER;
            CTF_OP_MC:     return MC_MASK_IN[c.imm[3:0]] ? CTF_PI_MON : CTF_PI_NONE;
            CTF_OP_DEC:    return c.sign_ok ? CTF_PI_NONE : CTF_PI_DATA;
            CTF_OP_EDIT:   return c.pat_prot ? CTF_PI_PROT : CTF_PI_NONE;
            CTF_OP_FETCHI: return c.addr[0] ? CTF_PI_SPEC : CTF_PI_NONE;
            CTF_OP_CHCMD:  return (c.addr[2:0] != 3'h0) ? CTF_PI_SPEC : CTF_PI_NONE;
            default:       return CTF_PI_NONE;
        endcase
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic go();
        CMD_VALID_IN = 1'b1;
        @(posedge CLK_IN) #2;
        r = RSP_OUT;
        chk(r.done, 1'b1);
    endtask
    task automatic idle(input int c);
        CMD_VALID_IN = 1'b0;
        repeat (c) @(posedge CLK_IN) #2;
    endtask
    task automatic gap(input logic t, output int c);
        logic [51:0] s;
        c = 0;
        s = t ? TOD_OUT : 52'(ITMR_OUT);
        while ((t ? TOD_OUT : 52'(ITMR_OUT)) === s && c < 2000)
        begin
            idle(1);
            c++;
        end
    endtask
    task automatic fin(input string s);
        $display("test %s done, mismatches %0d", s, mismatches);
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ************
    // Sequence
    // ************
    initial
    begin
        repeat (2) @(posedge CLK_IN) #2;
        chk({SYSMASK_OUT, KEY_OUT, TOD_OUT, ITMR_OUT}, 64'h0);
        RST_IN = 1'b0;
        m = SYSMASK_RST;
        for (n = 0; n < 12; n++)
        begin
            v = {rnd(), rnd()};
            CMD_IN.imm = (n == 0) ? 8'hFF : v[7:0];
            CMD_IN.op = n[0] ? CTF_OP_STNSM : CTF_OP_STOSM;
            go();
            chk(r.stor_wd[63:56], m);
            m = n[0] ? (m & CMD_IN.imm) : (m | CMD_IN.imm);
            chk(SYSMASK_OUT, m);
        end
        CMD_IN.opnd2 = v;
        CMD_IN.op = CTF_OP_SKEY;
        go();
        chk(KEY_OUT, v[7:4]);
        CMD_IN.op = CTF_OP_IKEY;
        go();
        chk({r.reg_we, r.reg_wd[7:4]}, {1'b1, v[7:4]});
        fin("mask_key");
        PROBLEM_STATE_IN = 1'b1;
        CMD_IN.opnd2 = ~v;
        foreach (pops[i])
        begin
            CMD_IN.op = pops[i];
            go();
            chk(r.pi, CTF_PI_PRIV);
            chk({r.stor_we, r.reg_we, SYSMASK_OUT, KEY_OUT}, {2'b00, m, v[7:4]});
        end
        PROBLEM_STATE_IN = 1'b0;
        fin("privilege");
        for (n = 0; n < 300; n++)
        begin
            v = {rnd(), rnd()};
            CMD_IN.op = ctf_op_e'(5'(3 + v[4:0] % 18));
            CMD_IN.imm = v[15:8];
            CMD_IN.addr = v[39:16];
            CMD_IN.opnd1 = v[42] ? 64'h0 : {rnd(), rnd()};
            CMD_IN.sign_ok = (CMD_IN.op != CTF_OP_DEC) | v[40];
            CMD_IN.pat_prot = v[41];
            MC_MASK_IN = v[63:48];
            go();
            chk(r.pi, exp_pi(CMD_IN));
            k = (CMD_IN.op == CTF_OP_CS) ?
                int'(CMD_IN.opnd1[31:0] == CMD_IN.stor[31:0]) :
                int'(CMD_IN.opnd1 == CMD_IN.stor);
            if (CMD_IN.op inside {CTF_OP_CS, CTF_OP_CDS})
                chk({r.cc0, r.stor_we, r.reg_we}, {k[0], k[0], ~k[0]});
            if (!CMD_IN.sign_ok)
                chk({r.stor_we, r.reg_we}, 2'b00);
            if (exp_pi(CMD_IN) == CTF_PI_MON)
                chk({r.mon_class, r.mon_code}, {CMD_IN.imm[3:0], CMD_IN.addr});
        end
        fin("random_ops");
        CLK_SET_EN_IN = 1'b1;
        CMD_IN.stor = v;
        CMD_IN.op = CTF_OP_SCK;
        go();
        CMD_IN.op = CTF_OP_STCK;
        go();
        chk(r.stor_wd, {v[63:16], 16'h0000});
        CLK_SET_EN_IN = 1'b0;
        CMD_IN.stor = ~v;
        CMD_IN.op = CTF_OP_SCK;
        go();
        chk({r.cc0, TOD_OUT[51:4]}, {1'b0, v[63:16]});
        gap(1'b1, k);
        gap(1'b1, k);
        chk(k, TOD_STEP_CYC);
        fin("clock");
        gap(1'b0, k);
        gap(1'b0, k);
        chk(k, ITC);
        STOPPED_IN = 1'b1;
        idle(1);
        v = 64'(ITMR_OUT);
        idle(30);
        chk(ITMR_OUT, v[31:0]);
        STOPPED_IN = 1'b0;
        fin("timer");
        wrap_up();
    end
endmodule
bind ctf_core ctf_core_asserts ctf_core_asserts_inst (.CLK_IN, .RST_IN,
    .CMD_VALID_IN, .CMD_IN, .PROBLEM_STATE_IN, .STOPPED_IN, .MC_MASK_IN,
    .RSP_OUT, .SYSMASK_OUT, .KEY_OUT, .TOD_OUT, .ITMR_OUT);
`default_nettype wire
